// ==== rtl/eeprom_host_pkg.sv ====
/*
  constants for the parallel eeprom host controller: widths, bit positions,
  timing figures and cycle counts. assumes a 100 MHz system clock.
*/
package eeprom_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LOW_W = 6;         // low address bits free within a page
  localparam int PAGE_BYTES = 64;
  localparam int POLL_BIT = 7;           // complemented-data poll line
  localparam int TOGGLE_BIT = 6;         // toggling status line
  localparam int CLK_NS = 10;
  // byte load window, least-time view for the host: stay well inside it
  localparam int LOAD_WIN_NS = 100000;
  localparam int LOAD_WIN_CYC = LOAD_WIN_NS / CLK_NS;
  // phase lengths on the pins, in ns and in cycles (rounded up)
  localparam int SETUP_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 200;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 50;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // typical self-timed programming time; the poll time-out guard is twice it
  localparam int PROG_MS = 5;
  localparam int PROG_LIMIT_NS = 2 * PROG_MS * 1000000;
  localparam int PROG_LIMIT_CYC = PROG_LIMIT_NS / CLK_NS;
  localparam int CNT_W = 24;
endpackage

// ==== rtl/eeprom_host.sv ====
/*
  host-side controller for a byte-wide parallel eeprom: drives the select,
  output gate and write strobes, the address lines and the data lines, and
  waits for write completion by polling. assumes a single 100 MHz clock and
  that data line inputs arrive from the pins asynchronously.
*/
// Contract
// - read only with select and gate low
// - write needs select, strobe low, gate high
// - up to 64 bytes per page load
// - page bytes share upper nine address bits
// - next strobe within 100 us of last
`timescale 1ns/100ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int LOAD_WIN = LOAD_WIN_CYC,
  parameter int PROG_LIMIT = PROG_LIMIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  // user request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqLast,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] reqData,
  output logic rdValid,
  output logic [eeprom_host_pkg::DATA_W-1:0] rdData,
  output logic wrDone,
  output logic wrTimeout,
  output logic pageErr,
  // device pins
  output logic chipSelN,
  output logic outGateN,
  output logic writeStrobeN,
  output logic [eeprom_host_pkg::ADDR_W-1:0] address_lines,
  output logic [eeprom_host_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] data_lines_i
);
  import eeprom_host_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b000, WSET = 3'b001, WSTB = 3'b010, WHOLD = 3'b011,
    WWAIT = 3'b100, RSET = 3'b101, RSTB = 3'b110, POLL = 3'b111
  } state_e;

  state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] winCnt_r;
  logic [CNT_W-1:0] progCnt_r;
  logic [DATA_W-1:0] sync1_r;
  logic [DATA_W-1:0] sync2_r;
  logic [ADDR_W-1:0] lastAddr_r;
  logic [DATA_W-1:0] lastData_r;
  logic [ADDR_W-PAGE_LOW_W-1:0] pageAddr_r;
  logic [6:0] pageCnt_r;
  logic reqLast_r;
  logic pollFinish;
  logic pollPhase_r;
  logic [DATA_W-1:0] pollPrev_r;
  logic cntDone;
  logic samePage;
  logic pageFull;

  assign cntDone = (cnt_r == '0);
  assign samePage = (reqAddr[ADDR_W-1:PAGE_LOW_W] == pageAddr_r);
  assign pageFull = (pageCnt_r == 7'(PAGE_BYTES));
  // requests only taken while idle or with a page still open for loading
  // a closed page, or a lapsed window, takes no further byte
  assign reqReady = (state_r == IDLE) ||
                    (state_r == WWAIT && reqWrite && samePage && !pageFull &&
                     !reqLast_r && winCnt_r != '0);

  // two-flop synchroniser on data line inputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= data_lines_i;
      sync2_r <= sync1_r;
    end
  end

  // main sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= IDLE;
      cnt_r <= '0;
    end else begin
      if (!cntDone) cnt_r <= cnt_r - 1'b1;
      unique case (state_r)
        IDLE: begin
          if (reqValid) begin
            state_r <= reqWrite ? WSET : RSET;
            cnt_r <= CNT_W'(SETUP_CYC);
          end
        end
        WSET: if (cntDone) begin
          state_r <= WSTB;
          cnt_r <= CNT_W'(STROBE_CYC);
        end
        WSTB: if (cntDone) begin
          state_r <= WHOLD;
          cnt_r <= CNT_W'(HOLD_CYC);
        end
        WHOLD: if (cntDone) state_r <= WWAIT;
        WWAIT: begin
          if (reqValid && reqReady) begin
            state_r <= WSET;
            cnt_r <= CNT_W'(SETUP_CYC);
          // window lapse ends load
          // a full or closed page still sits out the window: polling earlier
          // would read true data before the device has even started
          end else if (winCnt_r == '0) begin
            state_r <= RSET;
            cnt_r <= CNT_W'(SETUP_CYC);
          end
        end
        RSET: if (cntDone) begin
          state_r <= RSTB;
          cnt_r <= CNT_W'(ACCESS_CYC);
        end
        RSTB: if (cntDone) state_r <= pollPhase_r ? POLL : IDLE;
        POLL: begin
          state_r <= (pollFinish || progCnt_r == '0) ? IDLE : RSET;
          cnt_r <= CNT_W'(HOLD_CYC);
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // remembers whether the user closed the page with its last byte
  always_ff @(posedge clk) begin
    if (!rstn) reqLast_r <= 1'b0;
    else if (reqValid && reqReady && reqWrite) reqLast_r <= reqLast;
    else if (state_r == IDLE) reqLast_r <= 1'b0;
  end

  // byte load window counter restarts on each strobe fall
  always_ff @(posedge clk) begin
    if (!rstn) winCnt_r <= '0;
    else if (state_r == WSET && cntDone) winCnt_r <= CNT_W'(LOAD_WIN) - CNT_W'(STROBE_CYC + HOLD_CYC + 2 * SETUP_CYC);
    else if (winCnt_r != '0) winCnt_r <= winCnt_r - 1'b1;
  end

  // page bookkeeping and last byte written
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pageAddr_r <= '0;
      pageCnt_r <= '0;
      lastAddr_r <= '0;
      lastData_r <= '0;
    end else if (reqValid && reqReady && reqWrite) begin
      pageAddr_r <= reqAddr[ADDR_W-1:PAGE_LOW_W];
      pageCnt_r <= (state_r == IDLE) ? 7'd1 : pageCnt_r + 7'd1;
      lastAddr_r <= reqAddr;
      lastData_r <= reqData;
    end
  end

  // polling: one write enters poll phase, normal reads do not
  // inverted bit seven means busy; toggling line six means busy
  assign pollFinish = (sync2_r[POLL_BIT] == lastData_r[POLL_BIT]) && pollPrev_r[TOGGLE_BIT] == sync2_r[TOGGLE_BIT];
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pollPhase_r <= 1'b0;
      pollPrev_r <= '0;
      progCnt_r <= '0;
    end else begin
      // device programs alone, host only watches
      if (state_r == WWAIT && !(reqValid && reqReady) && winCnt_r == '0) begin
        pollPhase_r <= 1'b1;
        progCnt_r <= CNT_W'(PROG_LIMIT);
        pollPrev_r <= ~lastData_r;
      end else if (state_r == POLL) begin
        pollPrev_r <= sync2_r;
        // stop once toggling ceases and bit seven is true
        if (pollFinish || progCnt_r == '0) pollPhase_r <= 1'b0;
      end
      if (pollPhase_r && progCnt_r != '0) progCnt_r <= progCnt_r - 1'b1;
    end
  end

  // pins: write with gate high, read with select and gate low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chipSelN <= 1'b1;
      outGateN <= 1'b1;
      writeStrobeN <= 1'b1;
      address_lines <= '0;
      data_lines_o <= '0;
      data_lines_oe <= 1'b0;
    end else begin
      chipSelN <= !(state_r == WSTB || state_r == RSTB);
      // address stable before both fall; data held past rise
      writeStrobeN <= !(state_r == WSTB);
      outGateN <= !(state_r == RSTB);
      data_lines_oe <= (state_r == WSET || state_r == WSTB || state_r == WHOLD);
      if (reqValid && reqReady) begin
        address_lines <= reqAddr;
        data_lines_o <= reqData;
      end else if (state_r == WWAIT && winCnt_r == '0) begin
        address_lines <= lastAddr_r;
      end
    end
  end

  // answers to the user
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdValid <= 1'b0;
      rdData <= '0;
      wrDone <= 1'b0;
      wrTimeout <= 1'b0;
      pageErr <= 1'b0;
    end else begin
      rdValid <= (state_r == RSTB) && cntDone && !pollPhase_r;
      if ((state_r == RSTB) && cntDone) rdData <= sync2_r;
      wrDone <= (state_r == POLL) && pollFinish;
      // bit seven never settles when device is protected
      wrTimeout <= (state_r == POLL) && !pollFinish && progCnt_r == '0;
      pageErr <= (state_r == WWAIT) && reqValid && reqWrite && !samePage;
    end
  end
endmodule // eeprom_host

// ==== dv/eeprom_host_chk.sv ====
/* pin checker for eeprom_host; sees its ports only, one clock domain */
`timescale 1ns/100ps
module eeprom_host_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire logic chipSelN,
  input wire logic outGateN,
  input wire logic writeStrobeN,
  input wire logic [14:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic data_lines_oe,
  input wire logic pageErr,
  input wire logic wrDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // strobe and drive rules on the pins, plus done and page error rules on the user side
  a_strobe_gate_high: assert property (!writeStrobeN |-> outGateN && !chipSelN)
    else $error("strobe with gate low");
  a_drive_gate_high: assert property (data_lines_oe |-> outGateN)
    else $error("drive during read");
  a_read_no_strobe: assert property (!outGateN |-> writeStrobeN && !data_lines_oe)
    else $error("read overlaps write");
  a_addr_held_write: assert property (!writeStrobeN |-> $stable(address_lines))
    else $error("address moved");
  a_data_held_write: assert property (!writeStrobeN |-> data_lines_oe && $stable(data_lines_o))
    else $error("data moved");
  a_strobe_min_len: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*8])
    else $error("strobe short");
  a_done_one_cycle: assert property (wrDone |=> !wrDone)
    else $error("done too long");
  a_page_err_cause: assert property (pageErr |-> reqValid && writeStrobeN)
    else $error("page error unprovoked");
  c_write: cover property ($fell(writeStrobeN));
  c_read: cover property ($fell(outGateN));
  c_page_err: cover property (pageErr);
endmodule // eeprom_host_chk
bind eeprom_host eeprom_host_chk chk_u (.clk(clk), .rstn(rstn), .reqValid(reqValid),
  .chipSelN(chipSelN), .outGateN(outGateN), .writeStrobeN(writeStrobeN),
  .address_lines(address_lines), .data_lines_o(data_lines_o),
  .data_lines_oe(data_lines_oe), .pageErr(pageErr), .wrDone(wrDone));

// ==== dv/eeprom_dev.sv ====
/* pin model of the byte-wide eeprom; sampled on the host clock; protect makes it a locked part */
`timescale 1ns/100ps
module eeprom_dev #(
  parameter int WIN = 150,
  parameter int PROG = 600
) (
  input wire logic clk,
  input wire logic protect,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [14:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] mem [0:32767];
  logic [14:0] lastA = '0;
  logic [7:0] lastD = '0;
  logic wrSel = 0, rdSel = 0, loading = 0, busy = 0, tog = 0;
  int cnt = 0;
  // released bus starts from a known level and then flips to its inverse every cycle
  initial q = 8'h00;
  always @(posedge clk) begin
    wrSel <= !ceN && !weN && oeN;
    if (!ceN && !weN && oeN && !wrSel && !busy && !protect) begin
      lastA <= a;
      loading <= 1'b1;
      cnt <= 0;
    end else if (wrSel && (ceN || weN) && !busy && !protect) begin
      mem[lastA] <= d;
      lastD <= d;
    end else if (loading || busy) cnt <= cnt + 1;
    if (loading && cnt == WIN) begin
      loading <= 0;
      busy <= 1;
      cnt <= 0;
    end
    if (busy && cnt == PROG) busy <= 0;
  end
  always @(posedge clk) begin
    rdSel <= !ceN && !oeN;
    if (!ceN && !oeN && !rdSel && busy) tog <= !tog;
    if (ceN || oeN) q <= ~q;
    else if (busy) q <= {~lastD[7], tog, lastD[5:0]};
    else q <= mem[a];
  end
endmodule // eeprom_dev

// ==== dv/tb_eeprom_host.sv ====
/* bench for eeprom_host against eeprom_dev; one 100 MHz clock, inputs at negedge */
`timescale 1ns/100ps
module tb_eeprom_host;
  import eeprom_host_pkg::*;
  logic clk, rstn, reqValid, reqWrite, reqLast, protect;
  logic errSeen = 0;
  logic [ADDR_W-1:0] reqAddr, addrPins, pg;
  logic [DATA_W-1:0] reqData, dOut, q, bus, rdData;
  logic reqReady, rdValid, wrDone, wrTimeout, pageErr, csN, ogN, weN, dOe;
  logic [DATA_W-1:0] rdQ [$];
  logic [DATA_W-1:0] img [PAGE_BYTES];
  logic [1:0] wrQ [$];
  logic [31:0] seed = 32'h2ECFE8B7;
  int fails = 0, samples_checked = 0, i;
  always #5 clk = ~clk;
  assign bus = dOe ? dOut : q;
  eeprom_host #(.LOAD_WIN(200), .PROG_LIMIT(2000)) dut_u (.clk(clk), .rstn(rstn),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqLast(reqLast),
    .reqAddr(reqAddr), .reqData(reqData), .rdValid(rdValid), .rdData(rdData),
    .wrDone(wrDone), .wrTimeout(wrTimeout), .pageErr(pageErr), .chipSelN(csN),
    .outGateN(ogN), .writeStrobeN(weN), .address_lines(addrPins), .data_lines_o(dOut),
    .data_lines_oe(dOe), .data_lines_i(bus));
  eeprom_dev dev_u (.clk(clk), .protect(protect), .ceN(csN), .oeN(ogN), .weN(weN),
    .a(addrPins), .d(bus), .q(q));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmpR(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmpW(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t write status %b want %b", $time, got, exp);
    end
  endtask
  // offer one request and hold it until taken
  task automatic req(input logic w, input logic l, input logic [14:0] ad, input logic [7:0] dt);
    int n;
    @(negedge clk);
    {reqValid, reqWrite, reqLast, reqAddr, reqData} = {1'b1, w, l, ad, dt};
    #1;
    for (n = 0; n < 5000 && reqReady !== 1'b1; n++) @(negedge clk);
    // a request never taken counts as a mismatch
    if (reqReady !== 1'b1) fails++;
    @(negedge clk);
    reqValid = 0;
  endtask
  // results taken off the queues as they appear
  always @(negedge clk) begin
    if (rdValid === 1'b1) cmpR(rdData, rdQ.pop_front());
    if (wrDone === 1'b1 || wrTimeout === 1'b1) cmpW({wrDone, wrTimeout}, wrQ.pop_front());
    if (pageErr === 1'b1) errSeen = 1;
  end
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  initial begin
    {clk, rstn, reqValid, reqWrite, reqLast, protect} = '0;
    reqAddr = '0;
    reqData = '0;
    repeat (8) @(negedge clk);
    rstn = 1;
    seed = lfsr(seed);
    pg = {seed[14:6], 6'h00};
    wrQ.push_back(2'b10);
    for (i = 0; i < PAGE_BYTES; i++) begin
      seed = lfsr(seed);
      img[i] = seed[7:0];
      req(1'b1, i == PAGE_BYTES - 1, pg | 15'(i), seed[7:0]);
    end
    for (i = 0; i < PAGE_BYTES; i++) begin
      rdQ.push_back(img[i]);
      req(1'b0, 1'b0, pg | 15'(i), 8'h00);
    end
    // other page waits until the open page has programmed
    wrQ.push_back(2'b10);
    wrQ.push_back(2'b10);
    req(1'b1, 1'b0, pg, 8'h5A);
    req(1'b1, 1'b1, pg ^ 15'h0040, 8'hA5);
    rdQ.push_back(8'hA5);
    req(1'b0, 1'b0, pg ^ 15'h0040, 8'h00);
    rdQ.push_back(8'h5A);
    req(1'b0, 1'b0, pg, 8'h00);
    // locked device: poll never settles, host gives up, byte unchanged
    @(negedge clk);
    protect = 1'b1;
    wrQ.push_back(2'b01);
    req(1'b1, 1'b1, pg | 15'h0001, img[1] ^ 8'h80);
    rdQ.push_back(img[1]);
    req(1'b0, 1'b0, pg | 15'h0001, 8'h00);
    protect = 1'b0;
    repeat (50) @(negedge clk);
    cmpW({errSeen, 1'b0}, 2'b10);
    cmpW({1'(rdQ.size()), 1'(wrQ.size())}, 2'b00);
    report_and_stop();
  end
endmodule // tb_eeprom_host
